// ---- core/bemh_pkg.sv ----
// package for the bar end m-code handshake block: register map, field layout, timing
// assumes a single 20 MHz controller clock and a 32-bit apb register bus
package bemh_pkg;

	// ==========================================================
	// bus
	localparam int unsigned ADDR_W    = 4;
	localparam int unsigned DATA_W    = 32;
	localparam logic [3:0]  OFF_CTRL  = 4'h0;
	localparam logic [3:0]  OFF_STAT  = 4'h4;
	localparam logic [3:0]  OFF_IRQ   = 4'h8;
	localparam logic [3:0]  OFF_MASK  = 4'hc;

	// ==========================================================
	// control register fields
	localparam int unsigned CTRL_STANDSTILL = 0;
	localparam int unsigned CTRL_FEED_MCODE = 1;
	localparam int unsigned CTRL_ACTION_LO  = 2;
	localparam int unsigned CTRL_EOB_CLEAR  = 4;
	localparam int unsigned CTRL_W          = 4;
	localparam logic [3:0]  CTRL_RST        = 4'h2;

	// ==========================================================
	// status register fields
	localparam int unsigned STAT_EOB    = 0;
	localparam int unsigned STAT_CLAMP  = 1;
	localparam int unsigned STAT_FEED   = 2;
	localparam int unsigned STAT_ACK    = 3;
	localparam int unsigned STAT_ST_LO  = 4;

	// ==========================================================
	// interrupt bits, same layout in status and mask
	localparam int unsigned INT_ACK   = 0;
	localparam int unsigned INT_EOB   = 1;
	localparam int unsigned INT_FEED  = 2;
	localparam int unsigned INT_W     = 3;
	localparam logic [2:0]  INT_RST   = 3'h0;

	// ==========================================================
	// timing
	localparam int unsigned CLK_HZ    = 20_000_000;
	localparam int unsigned DWELL_MS  = 500;
	localparam int unsigned DWELL_CYC = DWELL_MS * (CLK_HZ / 1000);
	localparam int unsigned CNT_W     = 24;
	localparam int unsigned SYNC_W    = 5;
	localparam logic [4:0]  SYNC_RST  = 5'h02; // clamp pin idles closed

	// ==========================================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PUSH,
		ST_FEED,
		ST_DWELL,
		ST_ACK
	} bemh_state_t;

endpackage : bemh_pkg

// ---- core/bemh_tmr_if.sv ----
// interface between the sequencer and its dwell timer
// assumes both ends sit on the same clock
`timescale 1ns/1ns
`default_nettype none

interface bemh_tmr_if;
	logic start;
	logic done;
	modport ctl (output start, input done);
	modport tmr (input start, output done);
endinterface : bemh_tmr_if

`default_nettype wire

// ---- core/bemh_dwell.sv ----
// dwell timer: one-cycle done pulse a fixed number of cycles after a start pulse
// assumes start is a one-cycle pulse; a new start restarts the count
`timescale 1ns/1ns
`default_nettype none

module bemh_dwell #(
	parameter int unsigned CYCLES = bemh_pkg::DWELL_CYC
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// timer port
	bemh_tmr_if.tmr   tmr
);
	import bemh_pkg::*;

	logic [CNT_W-1:0] count;
	logic             busy;
	logic             done;
	logic [CNT_W-1:0] next_count;
	logic             next_busy;
	logic             next_done;

	// ==========================================================
	// next state
	always_comb begin
		next_count = count;
		next_busy  = busy;
		next_done  = 1'b0;
		if (tmr.start) begin
			next_busy  = 1'b1;
			next_count = CNT_W'(CYCLES - 1);
		end else if (busy) begin
			if (count == '0) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end else begin
				next_count = count - 1'b1;
			end
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else if (ce_i) begin
			count <= next_count;
			busy  <= next_busy;
			done  <= next_done;
		end
	end

	assign tmr.done = done;

endmodule : bemh_dwell

`default_nettype wire

// ---- core/bemh_top.sv ----
// bar end m-code sequencer: sorts lathe m-codes into feed commands and end-of-bar tests
// assumes lathe and motion pins are asynchronous; registers reached over apb
//
// Functional notes
// - m-code with clamp closed is an end-of-bar test, never a feed
// - pusher test, no end of bar: move forward, on stall/face acknowledge and retract
// - end of bar seen in test forward motion is handled per action setting
// - pusher test, end of bar declared: no motion, dwell 0.5 s, ack, handle
// - stand-still test, no end of bar: acknowledge at once, no motion
// - stand-still test, end of bar declared: dwell 0.5 s then acknowledge
// - feed-on-m-code: first m-code after clamp opens starts feeding
// - feed-on-m-code: later m-codes are tests, acked at once or after dwell
// - open-clamp tests never move the pusher; feeding lasts while clamp open
// - without feed-on-m-code: feed on clamp opening, all open-clamp m-codes test
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none

module bemh_top #(
	parameter int unsigned DWELL_CYCLES = bemh_pkg::DWELL_CYC
) (
	// clock and reset
	input  wire logic                          MCLK_I,
	input  wire logic                          RST_I,
	input  wire logic                          CE_I,
	// apb slave
	input  wire logic                          PSEL_I,
	input  wire logic                          PENABLE_I,
	input  wire logic                          PWRITE_I,
	input  wire logic [bemh_pkg::ADDR_W-1:0]   PADDR_I,
	input  wire logic [bemh_pkg::DATA_W-1:0]   PWDATA_I,
	output logic      [bemh_pkg::DATA_W-1:0]   PRDATA_O,
	output logic                               PREADY_O,
	output logic                               PSLVERR_O,
	// lathe
	input  wire logic                          MCODE_REQ_I,
	input  wire logic                          CLAMP_CLOSED_I,
	output logic                               MCODE_ACK_O,
	// motion control
	input  wire logic                          PUSHER_CONTACT_I,
	input  wire logic                          AT_COLLET_FACE_I,
	input  wire logic                          END_OF_BAR_DETECT_I,
	output logic                               PUSH_FWD_O,
	output logic                               RETRACT_O,
	output logic                               FEED_O,
	output logic                               END_OF_BAR_HANDLE_O,
	output logic      [1:0]                    END_OF_BAR_ACTION_O,
	output logic                               END_OF_BAR_O,
	// interrupt
	output logic                               IRQ_O
);
	import bemh_pkg::*;

	// ==========================================================
	// decode
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = (a == OFF_CTRL) || (a == OFF_STAT) || (a == OFF_IRQ) || (a == OFF_MASK);
	endfunction : is_mapped

	// ==========================================================
	// pin synchronisers
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	logic              req_s;
	logic              clamp_s;
	logic              contact_s;
	logic              face_s;
	logic              eob_det_s;

	// stage one is read only by stage two
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			// clamp resets closed so that release of reset is no false opening
			sync1 <= SYNC_RST;
			sync2 <= SYNC_RST;
		end else if (CE_I) begin
			sync1 <= {END_OF_BAR_DETECT_I, AT_COLLET_FACE_I, PUSHER_CONTACT_I, CLAMP_CLOSED_I, MCODE_REQ_I};
			sync2 <= sync1;
		end
	end

	assign req_s     = sync2[0];
	assign clamp_s   = sync2[1];
	assign contact_s = sync2[2];
	assign face_s    = sync2[3];
	assign eob_det_s = sync2[4];

	// ==========================================================
	// sequencer state
	bemh_state_t state;
	bemh_state_t next_state;
	logic        req_q;
	logic        clamp_q;
	logic        ack;
	logic        push;
	logic        retract;
	logic        feed;
	logic        handle;
	logic        eob_decl;
	logic        feed_pending;
	logic        handle_after;
	logic        tmr_start;
	logic        next_ack;
	logic        next_push;
	logic        next_retract;
	logic        next_feed;
	logic        next_handle;
	logic        next_eob_decl;
	logic        next_feed_pending;
	logic        next_handle_after;
	logic        next_tmr_start;
	logic [INT_W-1:0] events;

	// bus state
	logic [CTRL_W-1:0] ctrl;
	logic [INT_W-1:0]  int_stat;
	logic [INT_W-1:0]  int_mask;
	logic [DATA_W-1:0] prdata;
	logic              pready;
	logic              pslverr;
	logic              irq;
	logic [CTRL_W-1:0] next_ctrl;
	logic [INT_W-1:0]  next_int_stat;
	logic [INT_W-1:0]  next_int_mask;
	logic [DATA_W-1:0] next_prdata;
	logic              next_pready;
	logic              next_pslverr;
	logic              next_irq;
	logic              wr_en;
	logic              eob_clear;

	logic req_rise;
	logic clamp_open_rise;
	logic standstill;
	logic feed_mcode;

	bemh_tmr_if tmr ();

	assign req_rise        = req_s & ~req_q;
	assign clamp_open_rise = clamp_q & ~clamp_s;
	assign standstill      = ctrl[CTRL_STANDSTILL];
	assign feed_mcode      = ctrl[CTRL_FEED_MCODE];
	assign tmr.start       = tmr_start;

	bemh_dwell #(
		.CYCLES (DWELL_CYCLES)
	) u_dwell (
		.clk_i (MCLK_I),
		.rst_i (RST_I),
		.ce_i  (CE_I),
		.tmr   (tmr)
	);

	// ==========================================================
	// sequencer next state
	always_comb begin
		next_state        = state;
		next_ack          = ack;
		next_push         = push;
		next_retract      = 1'b0;
		next_feed         = feed;
		next_handle       = 1'b0;
		next_eob_decl     = eob_decl;
		next_feed_pending = feed_pending;
		next_handle_after = handle_after;
		next_tmr_start    = 1'b0;
		events            = '0;
		// a detection wins over a software clear in the same cycle
		if (eob_det_s) begin
			next_eob_decl    = 1'b1;
			events[INT_EOB]  = ~eob_decl;
		end else if (eob_clear) begin
			next_eob_decl = 1'b0;
		end
		if (clamp_open_rise) begin
			next_feed_pending = feed_mcode;
			if (!feed_mcode) begin
				next_feed        = 1'b1;
				events[INT_FEED] = 1'b1;
			end
		end
		if (clamp_s) begin
			next_feed         = 1'b0;
			next_feed_pending = 1'b0;
		end
		case (state)
			ST_IDLE: begin
				if (req_rise) begin
					if (clamp_s) begin
						if (!standstill && !eob_decl) begin
							next_push  = 1'b1;
							next_state = ST_PUSH;
						end else if (!standstill) begin
							next_handle_after = 1'b1;
							next_tmr_start    = 1'b1;
							next_state        = ST_DWELL;
						end else if (!eob_decl) begin
							next_ack   = 1'b1;
							next_state = ST_ACK;
						end else begin
							next_handle_after = 1'b0;
							next_tmr_start    = 1'b1;
							next_state        = ST_DWELL;
						end
					end else if (feed_pending) begin
						next_feed_pending = 1'b0;
						next_feed         = 1'b1;
						events[INT_FEED]  = 1'b1;
						next_state        = ST_FEED;
					end else if (eob_decl) begin
						next_handle_after = 1'b0;
						next_tmr_start    = 1'b1;
						next_state        = ST_DWELL;
					end else begin
						next_ack   = 1'b1;
						next_state = ST_ACK;
					end
				end
			end
			ST_PUSH: begin
				if (eob_det_s) begin
					next_push   = 1'b0;
					next_handle = 1'b1;
					next_ack    = 1'b1;
					next_state  = ST_ACK;
				end else if (contact_s || face_s) begin
					next_push    = 1'b0;
					next_retract = 1'b1;
					next_ack     = 1'b1;
					next_state   = ST_ACK;
				end
			end
			ST_FEED: begin
				// sign off once the bar is against the stopper or in position, or once the clamp closes
				if (contact_s || face_s || clamp_s) begin
					next_ack   = 1'b1;
					next_state = ST_ACK;
				end
			end
			ST_DWELL: begin
				if (tmr.done) begin
					next_ack    = 1'b1;
					next_handle = handle_after;
					next_state  = ST_ACK;
				end
			end
			ST_ACK: begin
				if (!req_s) begin
					next_ack   = 1'b0;
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_ack   = 1'b0;
				next_push  = 1'b0;
			end
		endcase
		events[INT_ACK] = next_ack & ~ack;
	end

	// ==========================================================
	// sequencer registers
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			state        <= ST_IDLE;
			req_q        <= 1'b0;
			clamp_q      <= 1'b1;
			ack          <= 1'b0;
			push         <= 1'b0;
			retract      <= 1'b0;
			feed         <= 1'b0;
			handle       <= 1'b0;
			eob_decl     <= 1'b0;
			feed_pending <= 1'b0;
			handle_after <= 1'b0;
			tmr_start    <= 1'b0;
		end else if (CE_I) begin
			state        <= next_state;
			req_q        <= req_s;
			clamp_q      <= clamp_s;
			ack          <= next_ack;
			push         <= next_push;
			retract      <= next_retract;
			feed         <= next_feed;
			handle       <= next_handle;
			eob_decl     <= next_eob_decl;
			feed_pending <= next_feed_pending;
			handle_after <= next_handle_after;
			tmr_start    <= next_tmr_start;
		end
	end

	// ==========================================================
	// apb registers and interrupt
	assign wr_en     = PSEL_I & PENABLE_I & PWRITE_I & pready;
	assign eob_clear = wr_en & (PADDR_I == OFF_CTRL) & PWDATA_I[CTRL_EOB_CLEAR];

	// one wait state keeps pready and prdata straight from flops
	always_comb begin
		next_ctrl     = ctrl;
		next_int_mask = int_mask;
		next_int_stat = int_stat;
		next_pready   = PSEL_I & PENABLE_I & ~pready;
		next_pslverr  = 1'b0;
		next_prdata   = '0;
		if (wr_en && PADDR_I == OFF_CTRL) begin
			next_ctrl = PWDATA_I[CTRL_W-1:0];
		end
		if (wr_en && PADDR_I == OFF_MASK) begin
			next_int_mask = PWDATA_I[INT_W-1:0];
		end
		// set wins over the write-one clear
		if (wr_en && PADDR_I == OFF_IRQ) begin
			next_int_stat = int_stat & ~PWDATA_I[INT_W-1:0];
		end
		next_int_stat = next_int_stat | events;
		if (next_pready) begin
			next_pslverr = ~is_mapped(PADDR_I);
			case (PADDR_I)
				OFF_CTRL: next_prdata = {{(DATA_W-CTRL_W){1'b0}}, ctrl};
				OFF_STAT: next_prdata = {{(DATA_W-7){1'b0}}, 3'(state), ack, feed, clamp_s, eob_decl};
				OFF_IRQ:  next_prdata = {{(DATA_W-INT_W){1'b0}}, int_stat};
				OFF_MASK: next_prdata = {{(DATA_W-INT_W){1'b0}}, int_mask};
				default:  next_prdata = '0;
			endcase
		end
		next_irq = |(next_int_stat & next_int_mask);
	end

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			ctrl     <= CTRL_RST;
			int_stat <= INT_RST;
			int_mask <= INT_RST;
			prdata   <= '0;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			irq      <= 1'b0;
		end else if (CE_I) begin
			ctrl     <= next_ctrl;
			int_stat <= next_int_stat;
			int_mask <= next_int_mask;
			prdata   <= next_prdata;
			pready   <= next_pready;
			pslverr  <= next_pslverr;
			irq      <= next_irq;
		end
	end

	// ==========================================================
	// outputs
	assign PRDATA_O            = prdata;
	assign PREADY_O            = pready;
	assign PSLVERR_O           = pslverr;
	assign MCODE_ACK_O         = ack;
	assign PUSH_FWD_O          = push;
	assign RETRACT_O           = retract;
	assign FEED_O              = feed;
	assign END_OF_BAR_HANDLE_O = handle;
	assign END_OF_BAR_ACTION_O = ctrl[CTRL_ACTION_LO+1:CTRL_ACTION_LO];
	assign END_OF_BAR_O        = eob_decl;
	assign IRQ_O               = irq;

endmodule : bemh_top

`default_nettype wire

// ---- tb/bemh_assertions.sv ----
// checker for the bar end m-code sequencer: handshake, motion and feed relations
// assumes it is bound to bemh_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none

module bemh_chk (
	// clock and reset
	input wire logic MCLK_I,
	input wire logic RST_I,
	// lathe and motion inputs
	input wire logic MCODE_REQ_I,
	input wire logic CLAMP_CLOSED_I,
	input wire logic PUSHER_CONTACT_I,
	input wire logic END_OF_BAR_DETECT_I,
	// outputs watched
	input wire logic MCODE_ACK_O,
	input wire logic PUSH_FWD_O,
	input wire logic RETRACT_O,
	input wire logic FEED_O,
	input wire logic END_OF_BAR_HANDLE_O,
	input wire logic END_OF_BAR_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RST_I);

	// ==========================================================
	// sequences
	sequence s_closed;
		CLAMP_CLOSED_I [*4];
	endsequence
	sequence s_stall;
		PUSH_FWD_O && PUSHER_CONTACT_I;
	endsequence

	// ==========================================================
	// assertions
	a_ack_holds: assert property (MCODE_ACK_O && MCODE_REQ_I |=> MCODE_ACK_O)
		else $error("ack dropped while request held");
	a_ack_drops: assert property ($fell(MCODE_REQ_I) |-> ##[1:4] !MCODE_ACK_O)
		else $error("ack stuck after request withdrawn");
	a_closed_feed: assert property (s_closed |-> !FEED_O)
		else $error("feeding with clamp closed");
	a_feed_cause: assert property ($rose(FEED_O) |-> !$past(CLAMP_CLOSED_I, 3))
		else $error("feed started without clamp opening");
	a_push_cause: assert property ($rose(PUSH_FWD_O) |-> $past(MCODE_REQ_I, 3) && $past(CLAMP_CLOSED_I, 3))
		else $error("pusher moved without closed-clamp request");
	a_push_stops: assert property (s_stall |-> ##[1:4] !PUSH_FWD_O)
		else $error("pusher kept pushing after stall");
	a_retract_ack: assert property ($rose(RETRACT_O) |-> $rose(MCODE_ACK_O) && !PUSH_FWD_O)
		else $error("retract without sign-off");
	a_handle_ack: assert property ($rose(END_OF_BAR_HANDLE_O) |-> $rose(MCODE_ACK_O) && END_OF_BAR_O)
		else $error("end of bar handled without sign-off");
	a_eob_sets: assert property (END_OF_BAR_DETECT_I |-> ##[1:4] END_OF_BAR_O)
		else $error("end of bar not declared");
endmodule : bemh_chk

bind bemh_top bemh_chk u_chk (
	.MCLK_I              (MCLK_I),
	.RST_I               (RST_I),
	.MCODE_REQ_I         (MCODE_REQ_I),
	.CLAMP_CLOSED_I      (CLAMP_CLOSED_I),
	.PUSHER_CONTACT_I    (PUSHER_CONTACT_I),
	.END_OF_BAR_DETECT_I (END_OF_BAR_DETECT_I),
	.MCODE_ACK_O         (MCODE_ACK_O),
	.PUSH_FWD_O          (PUSH_FWD_O),
	.RETRACT_O           (RETRACT_O),
	.FEED_O              (FEED_O),
	.END_OF_BAR_HANDLE_O (END_OF_BAR_HANDLE_O),
	.END_OF_BAR_O        (END_OF_BAR_O)
);

`default_nettype wire

// ---- tb/bemh_lathe.sv ----
// lathe model: issues m-codes and drives the clamp state
// assumes one clock shared with the sequencer; all changes right after a rising edge
`timescale 1ns/1ns
`default_nettype none

module bemh_lathe (
	// clock
	input  wire logic clk_i,
	// handshake
	input  wire logic ack_i,
	output logic      req_o,
	output logic      clamp_closed_o
);
	initial begin
		req_o = 1'b0;
		clamp_closed_o = 1'b1;
	end

	task automatic clamp(input logic closed);
		@(posedge clk_i);
		clamp_closed_o <= closed;
	endtask : clamp

	// hold extends the request past the sign-off, like a slow lathe
	task automatic mcode(input logic [1:0] hold);
		int n;
		n = 0;
		@(posedge clk_i);
		req_o <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 2000);
		repeat (hold) @(posedge clk_i);
		req_o <= 1'b0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b0 && n < 4000);
	endtask : mcode
endmodule : bemh_lathe

`default_nettype wire

// ---- tb/tb_top.sv ----
// testbench for the bar end m-code sequencer
// assumes a shortened dwell; expectations queue up and a monitor compares them
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	import bemh_pkg::*;
	localparam int unsigned DW = 20;
	typedef struct {string nm; logic [32:0] v;} bemh_exp_t;

	logic        clk;
	logic        rst     = 1'b1;
	logic        psel    = 1'b0;
	logic        pen     = 1'b0;
	logic        pwr     = 1'b0;
	logic [3:0]  paddr   = 4'h0;
	logic [31:0] pwdata  = 32'h0;
	logic        contact = 1'b0;
	logic        face    = 1'b0;
	logic        detect  = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, req, clamp, ack, push, retract, feed, handle, end_of_bar, irq;
	logic [1:0]  action;
	logic [31:0] seed    = 32'h00013508;
	bemh_exp_t   expq[$];
	int          mismatches = 0;
	int          compares   = 0;
	int          lat        = 0;
	logic        pseen      = 1'b0;
	logic        ack_d      = 1'b0;
	logic        ce         = 1'b1;

	bemh_top #(.DWELL_CYCLES(DW)) DUT (
		.MCLK_I(clk), .RST_I(rst), .CE_I(ce),
		.PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.MCODE_REQ_I(req), .CLAMP_CLOSED_I(clamp), .MCODE_ACK_O(ack),
		.PUSHER_CONTACT_I(contact), .AT_COLLET_FACE_I(face), .END_OF_BAR_DETECT_I(detect),
		.PUSH_FWD_O(push), .RETRACT_O(retract), .FEED_O(feed), .END_OF_BAR_HANDLE_O(handle),
		.END_OF_BAR_ACTION_O(action), .END_OF_BAR_O(end_of_bar), .IRQ_O(irq)
	);
	bemh_lathe lathe (.clk_i(clk), .ack_i(ack), .req_o(req), .clamp_closed_o(clamp));

	// ==========================================================
	// helpers
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic cmp(input string nm, input logic [32:0] ex, input logic [32:0] sn);
		compares++;
		if (sn !== ex) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, ex, sn);
		end
	endtask : cmp

	task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// no own limit: the watchdog ends a hung transfer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		cmp("apb error", {32'h0, !(a inside {OFF_CTRL, OFF_STAT, OFF_IRQ, OFF_MASK})}, {32'h0, pslverr});
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task automatic rd(input string nm, input logic [3:0] a, input logic [32:0] ex);
		expq.push_back('{nm, ex});
		apb(1'b0, a, 32'h0);
	endtask : rd

	// random upper bits: only the low control bits may matter
	task automatic wctrl(input logic [4:0] v);
		logic [31:0] r;
		r = rnd();
		apb(1'b1, OFF_CTRL, {r[31:5], v});
	endtask : wctrl

	// one m-code; mot 1 contact, 2 end of bar, 3 collet face
	task automatic mc(input string nm, input int mot, input logic [6:0] ex);
		int n;
		logic [31:0] r;
		r = rnd();
		expq.push_back('{nm, {26'h0, ex}});
		fork
			lathe.mcode(r[1:0]);
			if (mot != 0) begin
				for (n = 0; n < 100 && push !== 1'b1 && feed !== 1'b1; n++) @(posedge clk);
				repeat (r[3:2]) @(posedge clk);
				contact <= (mot == 1);
				detect <= (mot == 2);
				face <= (mot == 3);
				for (n = 0; n < 200 && ack !== 1'b1; n++) @(posedge clk);
				contact <= 1'b0;
				detect <= 1'b0;
				face <= 1'b0;
			end
		join
		$display("test %s done", nm);
	endtask : mc

	// ==========================================================
	// monitor: sign-off snapshot {latency class, pushed, retract, handle, eob, feed}
	always @(posedge clk) begin
		if (psel && pen && !pwr && pready === 1'b1) begin
			cmp(expq[0].nm, expq[0].v, {pslverr, prdata});
			void'(expq.pop_front());
		end
		if (req && ack !== 1'b1) lat++;
		if (req && ack !== 1'b1 && push === 1'b1) pseen = 1'b1;
		if (ack === 1'b1 && !ack_d) begin
			cmp(expq[0].nm, expq[0].v, {26'h0, (lat <= 4) ? 2'h0 : (lat > DW) ? 2'h2 : 2'h1,
				pseen, retract, handle, end_of_bar, feed});
			void'(expq.pop_front());
			lat = 0;
			pseen = 1'b0;
		end
		ack_d = (ack === 1'b1);
	end

	task automatic stop_test();
		cmp("pending", 33'h0, 33'(expq.size()));
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test

	initial begin
		#(50 * 40000);
		mismatches++;
		stop_test();
	end

	// ==========================================================
	// tests
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd("ctrl reset", OFF_CTRL, {29'h0, CTRL_RST});
		apb(1'b1, OFF_MASK, 32'h7);
		rd("mask", OFF_MASK, 33'h7);
		apb(1'b1, 4'h6, rnd());
		rd("unmapped", 4'h2, 33'h100000000);
		$display("test registers done");
		wctrl(5'h01);
		mc("standstill", 0, 7'h00);
		wctrl(5'h00);
		mc("pusher contact", 1, 7'h38);
		mc("pusher face", 3, 7'h38);
		wctrl(5'h0c);
		mc("pusher end of bar", 2, 7'h36);
		cmp("action", 33'h3, {31'h0, action});
		rd("irq status", OFF_IRQ, 33'h3);
		apb(1'b1, OFF_MASK, 32'h0);
		repeat (2) @(posedge clk);
		cmp("irq masked", 33'h0, {32'h0, irq});
		apb(1'b1, OFF_MASK, 32'h7);
		repeat (2) @(posedge clk);
		cmp("irq raised", 33'h1, {32'h0, irq});
		apb(1'b1, OFF_IRQ, 32'h7);
		repeat (2) @(posedge clk);
		cmp("irq cleared", 33'h0, {32'h0, irq});
		mc("pusher declared", 0, 7'h46);
		wctrl(5'h01);
		mc("standstill declared", 0, 7'h42);
		wctrl(5'h12);
		rd("status cleared", OFF_STAT, 33'h2);
		lathe.clamp(1'b0);
		repeat (8) @(posedge clk);
		cmp("no feed before m-code", 33'h0, {32'h0, feed});
		mc("feed m-code", 1, 7'h21);
		mc("open test", 0, 7'h01);
		detect <= 1'b1;
		repeat (4) @(posedge clk);
		detect <= 1'b0;
		mc("open test declared", 0, 7'h43);
		lathe.clamp(1'b1);
		repeat (6) @(posedge clk);
		cmp("feed after close", 33'h0, {32'h0, feed});
		wctrl(5'h10);
		ce <= 1'b0;
		lathe.clamp(1'b0);
		repeat (6) @(posedge clk);
		cmp("frozen", 33'h0, {32'h0, feed});
		ce <= 1'b1;
		repeat (6) @(posedge clk);
		cmp("feed on opening", 33'h1, {32'h0, feed});
		mc("open test no feed m-code", 0, 7'h01);
		lathe.clamp(1'b1);
		repeat (6) @(posedge clk);
		stop_test();
	end
endmodule : tb_top

`default_nettype wire
